// >>> mdc_input_control.sv
// Input signal handling for a stepping motor driver, with APB register file.
// Assumes host lines synchronous-capable levels, a profile generator that
// reports motionBusy and step pulses, and alarm sources that pulse alarmEvent.
//
// The register addresses and the APB slave port were left to the implementer.
`include "mdc_params.svh"

module mdc_input_control
   import mdc_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire mdc_host_lines_t  hostLines,
   input  wire logic             motionBusy,
   input  wire logic             positioningActive,
   input  wire logic             stepPulse,
   input  wire logic             stepDirPositive,
   input  wire logic [7:0]       alarmEvent,
   output logic                  jogStart,
   output logic                  jogDirPositive,
   output mdc_jog_profile_t      jogProfile,
   output logic                  stopRequest,
   output mdc_stop_action_t      stopAction,
   output logic                  discardRemaining,
   output logic                  windingOn,
   output logic                  brakeRelease,
   output mdc_shaft_t            shaftState,
   output logic                  toolUnlock,
   output logic                  alarmActive,
   output logic      [23:0]      commandPosition
);

   // Source mapping: bit0 direct assigned, bit1 remote assigned
   function automatic logic resolveSource(input logic [1:0] srcMap,
                                          input logic       direct,
                                          input logic       remote);
      case (srcMap)
         2'h0:    resolveSource = 1'b1;            // unassigned reads as on
         2'h1:    resolveSource = direct;
         2'h2:    resolveSource = remote;
         default: resolveSource = direct & remote; // both must agree
      endcase
   endfunction : resolveSource

   function automatic logic inRange(input logic [31:0] value,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
      inRange = (value >= lo) && (value <= hi);
   endfunction : inRange

   // Synchronised host lines and their previous values
   mdc_host_lines_t sync1_reg;
   mdc_host_lines_t sync2_reg;
   mdc_host_lines_t prev_reg;
   mdc_host_lines_t rise;
   mdc_host_lines_t fall;

   // Settings
   logic [22:0]      jogDist_reg;
   logic [19:0]      jogSpeed_reg;
   logic [19:0]      jogAccel_reg;
   logic [19:0]      jogStartSpeed_reg;
   mdc_stop_action_t stopAct_reg;
   logic [23:0]      preset_reg;
   logic [4:0]       config_reg;

   // Block state
   logic [7:0]       alarm_reg;
   logic [23:0]      cmdPos_reg;
   mdc_exc_state_t  excState_reg;
   mdc_exc_state_t  excState_next;
   logic [15:0]      settleCnt_reg;
   logic             jogStart_reg;
   logic             jogDir_reg;
   logic             stopReq_reg;
   logic             discard_reg;
   logic             winding_reg;
   logic             brake_reg;
   mdc_shaft_t      shaft_reg;
   logic             unlock_reg;
   logic             alarmAny_reg;

   // APB answer
   logic [31:0]      prdata_reg;
   logic             pready_reg;
   logic             pslverr_reg;

   // Derived levels
   logic             excReq;
   logic             unlockNow;
   logic             stopCurrentOff;
   logic             currentAllowed;
   logic             brakeFitted;
   logic             setupPhase;
   logic             writeCommit;
   logic             mapped;
   logic             writable;
   logic             valueOk;
   logic [31:0]      readValue;
   logic [31:0]      statusWord;

   // Two-stage synchroniser; only stage two feeds logic
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else begin
         sync1_reg <= hostLines;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // One-cycle edge pulses per transition
   assign rise = sync2_reg & ~prev_reg;
   assign fall = ~sync2_reg & prev_reg;

   // Source resolution for the two mappable inputs
   assign excReq    = resolveSource(config_reg[`MDC_CFG_CON_LSB +: 2],
                                    sync2_reg.excitationDirect,
                                    sync2_reg.excitationRemote);
   assign unlockNow = resolveSource(config_reg[`MDC_CFG_UNL_LSB +: 2],
                                    sync2_reg.toolUnlockDirect,
                                    sync2_reg.toolUnlockRemote);
   assign brakeFitted = config_reg[`MDC_CFG_BRAKE_BIT];

   // Current removed after a stop with a current-off action, once at rest
   assign stopCurrentOff = sync2_reg.stopRequest && stopAct_reg[1] && !motionBusy;
   // Alarms and free run both cut current
   assign currentAllowed = excReq && !sync2_reg.freeRunRequest && !stopCurrentOff
                           && !alarmAny_reg;

   // APB phases: answer prepared at setup, committed at access
   assign setupPhase  = psel && !penable;
   assign writeCommit = psel && penable && pready_reg && pwrite && !pslverr_reg;

   // Address decode and access checks
   always_comb begin
      mapped   = 1'b1;
      writable = 1'b1;
      valueOk  = 1'b1;
      case (paddr)
         `MDC_OFF_JOG_DIST:  valueOk = inRange(pwdata, `MDC_DIST_MIN, `MDC_DIST_MAX);
         `MDC_OFF_JOG_SPEED: valueOk = inRange(pwdata, `MDC_RATE_MIN, `MDC_RATE_MAX);
         `MDC_OFF_JOG_ACCEL: valueOk = inRange(pwdata, `MDC_RATE_MIN, `MDC_RATE_MAX);
         `MDC_OFF_JOG_START: valueOk = inRange(pwdata, `MDC_START_MIN, `MDC_RATE_MAX);
         `MDC_OFF_STOP_ACT:  valueOk = 1'b1;
         `MDC_OFF_PRESET:    valueOk = 1'b1;
         `MDC_OFF_CONFIG:    valueOk = 1'b1;
         `MDC_OFF_STATUS:    writable = 1'b0;
         `MDC_OFF_CMD_POS:   writable = 1'b0;
         `MDC_OFF_ALARM:     writable = 1'b0;
         `MDC_OFF_INPUTS:    writable = 1'b0;
         default:            mapped = 1'b0;
      endcase
   end

   // Status word: sequence state, shaft, outputs, lock, motion
   assign statusWord = {23'h000000, motionBusy, unlock_reg, stopReq_reg, brake_reg,
                        winding_reg, shaft_reg, excState_reg};

   // Read multiplexer, settings zero-extended, positions sign-extended
   always_comb begin
      case (paddr)
         `MDC_OFF_JOG_DIST:  readValue = {9'h000, jogDist_reg};
         `MDC_OFF_JOG_SPEED: readValue = {12'h000, jogSpeed_reg};
         `MDC_OFF_JOG_ACCEL: readValue = {12'h000, jogAccel_reg};
         `MDC_OFF_JOG_START: readValue = {12'h000, jogStartSpeed_reg};
         `MDC_OFF_STOP_ACT:  readValue = {30'h00000000, stopAct_reg};
         `MDC_OFF_PRESET:    readValue = {{8{preset_reg[23]}}, preset_reg};
         `MDC_OFF_CONFIG:    readValue = {27'h0000000, config_reg};
         `MDC_OFF_STATUS:    readValue = statusWord;
         `MDC_OFF_CMD_POS:   readValue = {{8{cmdPos_reg[23]}}, cmdPos_reg};
         `MDC_OFF_ALARM:     readValue = {24'h000000, alarm_reg};
         `MDC_OFF_INPUTS:    readValue = {21'h000000, sync2_reg};
         default:            readValue = 32'h00000000;
      endcase
   end

   // APB answer: ready one cycle after setup, so no wait states
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else if (setupPhase) begin
         pready_reg  <= 1'b1;
         prdata_reg  <= pwrite ? 32'h00000000 : readValue;
         // Parameter writes refused while tools are locked
         pslverr_reg <= !mapped || (pwrite && (!writable || !valueOk || !unlock_reg));
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Jog settings, range-checked at setup
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         jogDist_reg       <= `MDC_RST_JOG_DIST;
         jogSpeed_reg      <= `MDC_RST_JOG_SPEED;
         jogAccel_reg      <= `MDC_RST_JOG_ACCEL;
         jogStartSpeed_reg <= `MDC_RST_JOG_START;
      end else if (writeCommit) begin
         case (paddr)
            `MDC_OFF_JOG_DIST:  jogDist_reg       <= pwdata[22:0];
            `MDC_OFF_JOG_SPEED: jogSpeed_reg      <= pwdata[19:0];
            `MDC_OFF_JOG_ACCEL: jogAccel_reg      <= pwdata[19:0];
            `MDC_OFF_JOG_START: jogStartSpeed_reg <= pwdata[19:0];
            default: ;
         endcase
      end
   end

   // Stop action, preset and mapping settings
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stopAct_reg <= mdc_stop_action_t'(`MDC_RST_STOP_ACT);
         preset_reg  <= `MDC_RST_PRESET;
         config_reg  <= `MDC_RST_CONFIG;
      end else if (writeCommit) begin
         case (paddr)
            `MDC_OFF_STOP_ACT: stopAct_reg <= mdc_stop_action_t'(pwdata[1:0]);
            `MDC_OFF_PRESET:   preset_reg  <= pwdata[23:0];
            `MDC_OFF_CONFIG:   config_reg  <= pwdata[4:0];
            default: ;
         endcase
      end
   end

   // Alarm latch; a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_reg <= 8'h00;
      end else begin
         alarm_reg <= (alarm_reg
                       & ~({8{fall.alarmClearRequest}} & `MDC_ALM_RESETTABLE)
                       & ~({8{fall.absErrorClearRequest}}
                           & (8'h01 << `MDC_ALM_ABS_BIT)))
                      | alarmEvent;
      end
   end

   // Any alarm held, registered for the output
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alarmAny_reg <= 1'b0;
      end else begin
         alarmAny_reg <= |alarm_reg;
      end
   end

   // Command position: preset edge gated by alarm and motion, else steps
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdPos_reg <= 24'h000000;
      end else if (rise.presetRequest && !alarmAny_reg && !(|alarm_reg)
                   && !motionBusy) begin
         cmdPos_reg <= preset_reg;
      end else if (stepPulse) begin
         cmdPos_reg <= stepDirPositive ? cmdPos_reg + 24'h000001
                                       : cmdPos_reg - 24'h000001;
      end
   end

   // Jog start pulse; positive wins a tie, refused while halted
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         jogStart_reg <= 1'b0;
         jogDir_reg   <= 1'b1;
      end else begin
         jogStart_reg <= (rise.jogPositiveRequest || rise.jogNegativeRequest)
                         && !sync2_reg.stopRequest && !alarmAny_reg;
         if (rise.jogPositiveRequest) begin
            jogDir_reg <= 1'b1;
         end else if (rise.jogNegativeRequest) begin
            jogDir_reg <= 1'b0;
         end
      end
   end

   // Halt request and discard of remaining travel
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stopReq_reg <= 1'b0;
         discard_reg <= 1'b0;
      end else begin
         stopReq_reg <= sync2_reg.stopRequest || (|alarm_reg);
         discard_reg <= rise.stopRequest && positioningActive;
      end
   end

   // Excitation sequence next state
   always_comb begin
      excState_next = excState_reg;
      case (excState_reg)
         MDC_EXC_OFF: begin
            if (currentAllowed) begin
               excState_next = MDC_EXC_SETTLE;
            end
         end
         MDC_EXC_SETTLE: begin
            if (!currentAllowed) begin
               excState_next = MDC_EXC_OFF;
            end else if (settleCnt_reg == 16'(`MDC_BRAKE_CYCLES - 1)) begin
               excState_next = MDC_EXC_HOLDING;
            end
         end
         MDC_EXC_HOLDING: begin
            if (!currentAllowed) begin
               excState_next = MDC_EXC_OFF;
            end
         end
         default: excState_next = MDC_EXC_OFF;
      endcase
   end

   // Sequence state and settle counter
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         excState_reg  <= MDC_EXC_OFF;
         settleCnt_reg <= 16'h0000;
      end else begin
         excState_reg <= excState_next;
         if (excState_reg == MDC_EXC_SETTLE) begin
            settleCnt_reg <= settleCnt_reg + 16'h0001;
         end else begin
            settleCnt_reg <= 16'h0000;
         end
      end
   end

   // Winding drive and brake; brake waits for settled excitation, except under free run
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         winding_reg <= 1'b0;
         brake_reg   <= 1'b0;
      end else begin
         winding_reg <= (excState_next != MDC_EXC_OFF);
         brake_reg   <= sync2_reg.freeRunRequest
                        || (excState_next == MDC_EXC_HOLDING);
      end
   end

   // Shaft state reported from the same terms that drive the motor
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shaft_reg <= MDC_SHAFT_RELEASED;
      end else if (sync2_reg.freeRunRequest) begin
         shaft_reg <= MDC_SHAFT_RELEASED;
      end else if (excState_next != MDC_EXC_OFF) begin
         shaft_reg <= MDC_SHAFT_HELD_EXCIT;
      end else begin
         shaft_reg <= brakeFitted ? MDC_SHAFT_HELD_BRAKE
                                  : MDC_SHAFT_RELEASED;
      end
   end

   // Setup tool lock level
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         unlock_reg <= 1'b0;
      end else begin
         unlock_reg <= unlockNow;
      end
   end

   // Outputs straight from flip-flops
   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign jogStart         = jogStart_reg;
   assign jogDirPositive   = jogDir_reg;
   assign jogProfile       = {jogDist_reg, jogSpeed_reg, jogAccel_reg,
                              jogStartSpeed_reg};
   assign stopRequest      = stopReq_reg;
   assign stopAction       = stopAct_reg;
   assign discardRemaining = discard_reg;
   assign windingOn        = winding_reg;
   assign brakeRelease     = brake_reg;
   assign shaftState       = shaft_reg;
   assign toolUnlock       = unlock_reg;
   assign alarmActive      = alarmAny_reg;
   assign commandPosition  = cmdPos_reg;

endmodule : mdc_input_control

// >>> mdc_params.svh
// Constants for the motor drive input control block.
// Assumes a 100 MHz ref_clk and an APB slave with 8 address bits in use.
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH

// Register byte offsets
`define MDC_OFF_JOG_DIST    8'h00
`define MDC_OFF_JOG_SPEED   8'h04
`define MDC_OFF_JOG_ACCEL   8'h08
`define MDC_OFF_JOG_START   8'h0c
`define MDC_OFF_STOP_ACT    8'h10
`define MDC_OFF_PRESET      8'h14
`define MDC_OFF_CONFIG      8'h18
`define MDC_OFF_STATUS      8'h1c
`define MDC_OFF_CMD_POS     8'h20
`define MDC_OFF_ALARM       8'h24
`define MDC_OFF_INPUTS      8'h28

// Reset values
`define MDC_RST_JOG_DIST    23'h000001
`define MDC_RST_JOG_SPEED   20'h003e8
`define MDC_RST_JOG_ACCEL   20'h003e8
`define MDC_RST_JOG_START   20'h001f4
`define MDC_RST_STOP_ACT    2'h1
`define MDC_RST_PRESET      24'h000000
`define MDC_RST_CONFIG      5'h00

// Accepted setting ranges
`define MDC_DIST_MIN        32'h00000001
`define MDC_DIST_MAX        32'h007fffff
`define MDC_RATE_MIN        32'h00000001
`define MDC_RATE_MAX        32'h000f4240
`define MDC_START_MIN       32'h00000000

// Config fields
`define MDC_CFG_CON_LSB     0
`define MDC_CFG_UNL_LSB     2
`define MDC_CFG_BRAKE_BIT   4

// Alarm bits
`define MDC_ALM_ABS_BIT     0
`define MDC_ALM_RESETTABLE  8'h3e

// Brake release settle time after excitation
`define MDC_CLK_PERIOD_NS   10
`define MDC_BRAKE_DELAY_NS  10000
`define MDC_BRAKE_CYCLES    ((`MDC_BRAKE_DELAY_NS + `MDC_CLK_PERIOD_NS - 1) / `MDC_CLK_PERIOD_NS)

`endif

// >>> mdc_pkg.sv
// Types shared by the motor drive input control block and its bench.
// Assumes mdc_params.svh for all numeric constants.
package mdc_pkg;

   // Host command lines, direct and remote sources where both exist
   typedef struct packed {
      logic jogPositiveRequest;
      logic jogNegativeRequest;
      logic stopRequest;
      logic excitationDirect;
      logic excitationRemote;
      logic freeRunRequest;
      logic presetRequest;
      logic alarmClearRequest;
      logic absErrorClearRequest;
      logic toolUnlockDirect;
      logic toolUnlockRemote;
   } mdc_host_lines_t;

   // Jog motion settings handed to the profile generator
   typedef struct packed {
      logic [22:0] distance;
      logic [19:0] runSpeed;
      logic [19:0] accelRate;
      logic [19:0] startSpeed;
   } mdc_jog_profile_t;

   typedef enum logic [1:0] {
      MDC_STOP_ABRUPT     = 2'h0,
      MDC_STOP_RAMP       = 2'h1,
      MDC_STOP_ABRUPT_OFF = 2'h2,
      MDC_STOP_RAMP_OFF   = 2'h3
   } mdc_stop_action_t;

   typedef enum logic [1:0] {
      MDC_SHAFT_RELEASED   = 2'h0,
      MDC_SHAFT_HELD_EXCIT = 2'h1,
      MDC_SHAFT_HELD_BRAKE = 2'h2
   } mdc_shaft_t;

   // Excitation sequence, Gray along off -> energising -> holding
   typedef enum logic [1:0] {
      MDC_EXC_OFF     = 2'b00,
      MDC_EXC_SETTLE  = 2'b01,
      MDC_EXC_HOLDING = 2'b11
   } mdc_exc_state_t;

endpackage : mdc_pkg

// >>> mdc_input_control_chk.sv
// Checker for the motor drive input control block.
// Assumes it is bound to the top module and sees only its ports.
module mdc_input_control_chk
   import mdc_pkg::*;
(
   input wire logic            ref_clk,
   input wire logic            reset_n,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire mdc_host_lines_t hostLines,
   input wire logic            jogStart,
   input wire logic            jogDirPositive,
   input wire logic            stopRequest,
   input wire logic            discardRemaining,
   input wire logic            windingOn,
   input wire logic            brakeRelease,
   input wire mdc_shaft_t      shaftState,
   input wire logic            alarmActive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Host lines reach outputs three edges late, through the synchroniser
   jog_pos_a: assert property (jogStart && jogDirPositive |-> $past(hostLines.jogPositiveRequest, 3))
      else $error("positive jog without request");
   jog_neg_a: assert property (jogStart && !jogDirPositive |-> $past(hostLines.jogNegativeRequest, 3))
      else $error("negative jog without request");
   jog_once_a: assert property (jogStart |=> !jogStart)
      else $error("jog start longer than one cycle");
   free_run_a: assert property (hostLines.freeRunRequest [*4] |->
      !windingOn && brakeRelease && shaftState == MDC_SHAFT_RELEASED)
      else $error("free run not honoured");
   brake_late_a: assert property ($rose(brakeRelease) && windingOn |-> $past(windingOn, 8))
      else $error("brake released before excitation");
   alarm_stop_a: assert property (alarmActive |-> stopRequest)
      else $error("alarm without stop");
   stop_line_a: assert property (hostLines.stopRequest [*4] |-> stopRequest)
      else $error("stop line ignored");
   discard_once_a: assert property (discardRemaining |=> !discardRemaining)
      else $error("discard longer than one cycle");
   refuse_reply_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   reply_time_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   cover property (jogStart);
   cover property ($rose(brakeRelease));
   cover property (pslverr);
endmodule : mdc_input_control_chk

// >>> mdc_host_model.sv
// Host controller model: presents command lines to the driver.
// Assumes the bench sets wanted levels; lines move just after an edge.
module mdc_host_model
   import mdc_pkg::*;
(
   input wire logic            ref_clk,
   input wire mdc_host_lines_t wantLines,
   output mdc_host_lines_t     hostLines
);
   // One edge of lag, like a controller output stage
   always_ff @(posedge ref_clk) begin
      hostLines <= wantLines;
   end
endmodule : mdc_host_model

// >>> mdc_input_control_tb.sv
// Self-checking bench for the motor drive input control block.
// Assumes the host model, the checker and mdc_params.svh beside it.
`include "mdc_params.svh"
module mdc_input_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mdc_pkg::*;
   logic             refClk = 1'b0, resetN = 1'b0, pready, pslverr, err;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, motionBusy = 1'b0;
   logic             posActive = 1'b0, jogStart, jogDirPositive, stopRequest;
   logic             discardRemaining, windingOn, brakeRelease, toolUnlock, alarmActive;
   logic [7:0]       paddr = 8'h00, alarmEvent = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic [23:0]      commandPosition;
   mdc_host_lines_t  wantLines = '0, hostLines, v;
   mdc_jog_profile_t jogProfile;
   mdc_stop_action_t stopAction;
   mdc_shaft_t       shaftState;
   int               failCount = 0, nTests = 0, nJog, nDis;
   logic             dir;
   always #5 refClk = ~refClk;
   mdc_host_model u_host (.ref_clk(refClk), .wantLines(wantLines), .hostLines(hostLines));
   // Step inputs tied: position counting is not exercised here
   mdc_input_control u_dut (.ref_clk(refClk), .reset_n(resetN), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hostLines(hostLines), .motionBusy(motionBusy),
      .positioningActive(posActive), .stepPulse(1'b0), .stepDirPositive(1'b0),
      .alarmEvent(alarmEvent), .jogStart(jogStart), .jogDirPositive(jogDirPositive),
      .jogProfile(jogProfile), .stopRequest(stopRequest), .stopAction(stopAction),
      .discardRemaining(discardRemaining), .windingOn(windingOn),
      .brakeRelease(brakeRelease), .shaftState(shaftState), .toolUnlock(toolUnlock),
      .alarmActive(alarmActive), .commandPosition(commandPosition));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out;
      if (failCount == 0 && nTests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic tick(input int n);
      repeat (n) @(negedge refClk);
   endtask : tick
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge refClk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge refClk);
      penable <= 1'b1;
      do begin
         @(posedge refClk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic put(input mdc_host_lines_t x, input int n);
      @(posedge refClk);
      wantLines <= x;
      tick(n);
   endtask : put
   // Counts jog and discard pulses over a fixed span
   task automatic count(input mdc_host_lines_t x);
      {nJog, nDis} = '0;
      put(x, 0);
      repeat (10) begin @(negedge refClk); nJog += int'(jogStart === 1'b1);
         nDis += int'(discardRemaining === 1'b1); if (jogStart === 1'b1) dir = jogDirPositive; end
   endtask : count
   task automatic t_defaults;
      logic [31:0] e [7] = '{32'h1, 32'h3e8, 32'h3e8, 32'h1f4, 32'h1, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check(rd, e[i]);
      end
      apb(1'b0, 8'h2c, 32'h0);
      check(32'(err), 32'h1);
      check(32'(jogProfile.runSpeed), 32'h3e8);
      check(32'(jogProfile.accelRate), 32'h3e8);
      check(32'(jogProfile.startSpeed), 32'h1f4);
   endtask : t_defaults
   task automatic t_settings;
      apb(1'b1, `MDC_OFF_JOG_DIST, 32'h0);
      check(32'(err), 32'h1);
      apb(1'b1, `MDC_OFF_JOG_DIST, 32'h7fffff);
      apb(1'b0, `MDC_OFF_JOG_DIST, 32'h0);
      check(rd, 32'h7fffff);
      check(32'(jogProfile.distance), 32'h7fffff);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `MDC_OFF_STOP_ACT, 32'(m));
         tick(2);
         check(32'(stopAction), 32'(m));
      end
      apb(1'b1, `MDC_OFF_CONFIG, 32'h0c);
      v = '0; v.toolUnlockDirect = 1'b1; put(v, 6);
      check(32'(toolUnlock), 32'h0);
      apb(1'b1, `MDC_OFF_JOG_SPEED, 32'h5);
      check(32'(err), 32'h1);
      v.toolUnlockRemote = 1'b1; put(v, 6);
      apb(1'b1, `MDC_OFF_CONFIG, 32'h0);
      check({toolUnlock, err}, 32'h2);
      put('0, 6);
   endtask : t_settings
   task automatic t_jog;
      for (int d = 0; d < 2; d++) begin
         v = '0; v.jogPositiveRequest = (d == 0); v.jogNegativeRequest = (d == 1);
         count(v);
         check({nJog[7:0], 7'h0, dir}, {8'h1, 7'h0, d == 0});
         put('0, 6);
      end
      @(posedge refClk);
      posActive <= 1'b1;
      v = '0; v.stopRequest = 1'b1; count(v);
      check({nDis[7:0], 7'h0, stopRequest}, {8'h1, 7'h0, 1'b1});
      v.jogPositiveRequest = 1'b1; count(v);
      check(32'(nJog), 32'h0);
      @(posedge refClk);
      posActive <= 1'b0;
      put('0, 6);
   endtask : t_jog
   task automatic t_excite;
      v = '0; v.freeRunRequest = 1'b1; put(v, 6);
      check({windingOn, brakeRelease, shaftState}, {2'b01, MDC_SHAFT_RELEASED});
      put('0, 6);
      check({windingOn, brakeRelease, shaftState}, {2'b10, MDC_SHAFT_HELD_EXCIT});
      tick(1010);
      check(32'(brakeRelease), 32'h1);
      apb(1'b1, `MDC_OFF_CONFIG, 32'h11);
      tick(6);
      check({windingOn, shaftState}, {1'b0, MDC_SHAFT_HELD_BRAKE});
      apb(1'b1, `MDC_OFF_CONFIG, 32'h0);
   endtask : t_excite
   task automatic t_preset;
      apb(1'b1, `MDC_OFF_PRESET, 32'hff800000);
      v = '0; v.presetRequest = 1'b1; put(v, 6);
      check(32'(commandPosition), 32'h800000);
      apb(1'b1, `MDC_OFF_PRESET, 32'h5);
      tick(4);
      check(32'(commandPosition), 32'h800000);
      put('0, 4);
      @(posedge refClk);
      motionBusy <= 1'b1;
      put(v, 6);
      check(32'(commandPosition), 32'h800000);
      put('0, 4);
      @(posedge refClk);
      motionBusy <= 1'b0;
   endtask : t_preset
   task automatic t_alarm;
      mdc_host_lines_t rc = '0, ac = '0;
      rc.alarmClearRequest = 1'b1;
      ac.absErrorClearRequest = 1'b1;
      for (int b = 0; b < 2; b++) begin
         @(posedge refClk); alarmEvent <= 8'h02 >> b;
         @(posedge refClk); alarmEvent <= 8'h00;
         tick(4);
         check({alarmActive, stopRequest}, 32'h3);
         v = '0;
         v.presetRequest = 1'b1;
         put(v, 6);
         check(32'(commandPosition), 32'h800000);
         put(b ? rc : ac, 4); put('0, 6);
         check(32'(alarmActive), 32'h1);
         put(b ? ac : rc, 4); put('0, 6);
         check(32'(alarmActive), 32'h0);
      end
   endtask : t_alarm
   initial begin
      repeat (3) @(posedge refClk);
      resetN <= 1'b1;
      t_defaults; t_settings; t_jog; t_excite; t_preset; t_alarm;
      close_out;
   end
   // Whole run is near 13 us; about eight times that means a hang
   initial begin
      #100us;
      failCount++;
      close_out;
   end
endmodule : mdc_input_control_tb
bind mdc_input_control mdc_input_control_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .hostLines(hostLines),
   .jogStart(jogStart), .jogDirPositive(jogDirPositive), .stopRequest(stopRequest),
   .discardRemaining(discardRemaining), .windingOn(windingOn), .brakeRelease(brakeRelease),
   .shaftState(shaftState), .alarmActive(alarmActive));
